/* logic/csf_reload_if.sv */
// Interface between the register logic and the continuous-force reload unit.
`default_nettype none

interface csf_reload_if;
   import pwm_force_pkg::*;

   logic             wr;
   logic [CSF_W-1:0] wdata;
   reload_e          mode;
   logic             zero_evt;
   logic             period_evt;
   logic [CSF_W-1:0] shadow;
   logic [CSF_W-1:0] active;

   modport ctrl (output wr, wdata, mode, zero_evt, period_evt, input shadow, active);
   modport unit (input wr, wdata, mode, zero_evt, period_evt, output shadow, active);
endinterface

`default_nettype wire

/* logic/csf_reload_unit.sv */
// Shadow and active copies of the continuous-force setting with reload control.
`default_nettype none

module csf_reload_unit
   import pwm_force_pkg::*;
(
   // Clock and reset.
   input wire logic    clk,
   input wire logic    rstn,
   // Register side.
   csf_reload_if.unit  rl
);

   // ************************************************************
   // State.
   // ************************************************************
   typedef struct packed
   {
      logic [CSF_W-1:0] shadow;
      logic [CSF_W-1:0] active;
   } reload_s;

   reload_s st_ff;
   reload_s nxt_st;
   logic    load_evt;

   // Picks the counter event that moves shadow into active.
   always_comb
   begin
      unique case (rl.mode)
         RLD_ZERO:   load_evt = rl.zero_evt;
         RLD_PERIOD: load_evt = rl.period_evt;
         RLD_EITHER: load_evt = rl.zero_evt | rl.period_evt;
         RLD_NOW:    load_evt = 1'b0;
      endcase
   end

   // Writes always land in the shadow so reads stay coherent in every mode.
   always_comb
   begin
      nxt_st = st_ff;
      if (rl.wr)
      begin
         nxt_st.shadow = rl.wdata;
      end
      if (rl.mode == RLD_NOW)
      begin
         if (rl.wr)
         begin
            nxt_st.active = rl.wdata;
         end
      end
      else if (load_evt)
      begin
         nxt_st.active = st_ff.shadow;
      end
   end

   // Registers the state.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff <= {CSF_RESET, CSF_RESET};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign rl.shadow = st_ff.shadow;
   assign rl.active = st_ff.active;

   // ************************************************************
   // Checks.
   // ************************************************************
   a_imm_direct_load: assert property (@(posedge clk) disable iff (!rstn)
      rl.wr && rl.mode == RLD_NOW |=> rl.active == $past(rl.wdata))
      else $error("Immediate write did not reach the active copy.");

   a_shadow_mode_hold: assert property (@(posedge clk) disable iff (!rstn)
      rl.mode != RLD_NOW && !load_evt |=> $stable(rl.active))
      else $error("Active copy changed without a reload event.");

   a_zero_reload: assert property (@(posedge clk) disable iff (!rstn)
      rl.mode == RLD_ZERO && rl.zero_evt |=> rl.active == $past(rl.shadow))
      else $error("Zero event did not reload the active copy.");

   c_period_reload: cover property (@(posedge clk) disable iff (!rstn)
      rl.mode == RLD_PERIOD && rl.period_evt && rl.shadow != rl.active);

endmodule

`default_nettype wire

/* logic/force_output_channel.sv */
// One PWM output: continuous force, one-shot force and event actions.
`default_nettype none

module force_output_channel
   import pwm_force_pkg::*;
(
   // Clock and reset.
   input wire logic    clk,
   input wire logic    rstn,
   // Action sources.
   input wire action_e evt_act,
   input wire logic    os_fire,
   input wire action_e os_act,
   input wire action_e csf,
   // Output level.
   output logic        level
);

   // ************************************************************
   // State.
   // ************************************************************
   typedef struct packed
   {
      logic level;
   } chan_s;

   chan_s st_ff;
   chan_s nxt_st;

   // Returns the level after one action on the current level.
   function automatic logic apply_act(input action_e act, input logic cur);
      logic res;
      res = cur;
      unique case (act)
         ACT_NONE:   res = cur;
         ACT_LOW:    res = 1'b0;
         ACT_HIGH:   res = 1'b1;
         ACT_TOGGLE: res = ~cur;
      endcase
      return res;
   endfunction

   // Continuous force first, then the one-shot, then the counter event.
   always_comb
   begin
      nxt_st = st_ff;
      if (csf == ACT_LOW)
      begin
         nxt_st.level = 1'b0;
      end
      else if (csf == ACT_HIGH)
      begin
         nxt_st.level = 1'b1;
      end
      else if (os_fire)
      begin
         nxt_st.level = apply_act(os_act, st_ff.level);
      end
      else
      begin
         nxt_st.level = apply_act(evt_act, st_ff.level);
      end
   end

   // Registers the state.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff <= chan_s'(LEVEL_RESET);
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign level = st_ff.level;

   // ************************************************************
   // Checks.
   // ************************************************************
   a_csf_hold_low: assert property (@(posedge clk) disable iff (!rstn)
      csf == ACT_LOW |=> level == 1'b0)
      else $error("Continuous low force not honoured.");

   a_csf_hold_high: assert property (@(posedge clk) disable iff (!rstn)
      csf == ACT_HIGH |=> level == 1'b1)
      else $error("Continuous high force not honoured.");

   a_os_toggle_level: assert property (@(posedge clk) disable iff (!rstn)
      os_fire && os_act == ACT_TOGGLE && (csf == ACT_NONE || csf == ACT_TOGGLE)
      |=> level != $past(level))
      else $error("One-shot toggle did not invert the output.");

   a_evt_overrides_os: assert property (@(posedge clk) disable iff (!rstn)
      !os_fire && evt_act == ACT_LOW && (csf == ACT_NONE || csf == ACT_TOGGLE)
      |=> level == 1'b0)
      else $error("Event action did not override the output.");

   c_os_then_event: cover property (@(posedge clk) disable iff (!rstn)
      os_fire && os_act == ACT_HIGH ##[1:8] evt_act == ACT_LOW);

endmodule

`default_nettype wire

/* logic/pwm_action_software_force.sv */
// Software force stage of the PWM action qualifier with its register port.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`default_nettype none

module pwm_action_software_force
   import pwm_force_pkg::*;
(
   // Clock and reset.
   input wire logic              clk,
   input wire logic              rstn,
   // Register port.
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [REG_W-1:0]  reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   output logic [REG_W-1:0]      reg_rdata,
   // Time-base counter events.
   input wire logic              cnt_zero,
   input wire logic              cnt_period,
   // Actions from the event-driven action tables.
   input wire logic [ACT_W-1:0]  evt_act_a,
   input wire logic [ACT_W-1:0]  evt_act_b,
   // Outputs towards the dead-band stage.
   output logic                  pwm_output_a,
   output logic                  pwm_output_b
);

   // ************************************************************
   // Register state.
   // ************************************************************
   typedef struct packed
   {
      reload_e          rld;
      action_e          act_b;
      action_e          act_a;
      logic [REG_W-1:0] rdata;
   } regs_s;

   regs_s st_ff;
   regs_s nxt_st;

   // Address decode.
   logic wr_one_shot;
   logic wr_continuous;
   logic rd_one_shot;
   logic rd_continuous;

   // Per-output action sources, index 0 is output A and 1 is output B.
   logic    os_fire [NUM_OUT];
   action_e os_act  [NUM_OUT];
   action_e csf_act [NUM_OUT];
   action_e evt_act [NUM_OUT];
   logic    level   [NUM_OUT];

   // Read images of both registers.
   logic [REG_W-1:0] one_shot_image;
   logic [REG_W-1:0] continuous_image;

   csf_reload_if rl ();

   // ************************************************************
   // Decode.
   // ************************************************************

   // Strobes are qualified by the register address.
   assign wr_one_shot   = reg_wr && reg_addr == ADDR_ONE_SHOT;
   assign wr_continuous = reg_wr && reg_addr == ADDR_CONTINUOUS;
   assign rd_one_shot   = reg_rd && reg_addr == ADDR_ONE_SHOT;
   assign rd_continuous = reg_rd && reg_addr == ADDR_CONTINUOUS;

   // A trigger fires only in the write cycle that carries a 1 in its bit.
   // Nothing stores it, so it is gone as soon as the write is over.
   assign os_fire[1] = wr_one_shot && reg_wdata[TRIG_B_BIT];
   assign os_fire[0] = wr_one_shot && reg_wdata[TRIG_A_BIT];

   // The action applied is the one written beside the trigger.
   assign os_act[1] = action_e'(reg_wdata[ACT_B_LSB +: ACT_W]);
   assign os_act[0] = action_e'(reg_wdata[ACT_A_LSB +: ACT_W]);

   // Continuous force comes from the active copy only.
   assign csf_act[1] = action_e'(rl.active[CSF_B_LSB +: ACT_W]);
   assign csf_act[0] = action_e'(rl.active[CSF_A_LSB +: ACT_W]);

   assign evt_act[1] = action_e'(evt_act_b);
   assign evt_act[0] = action_e'(evt_act_a);

   // ************************************************************
   // Read images.
   // ************************************************************

   // Trigger and unused bits are left at zero in the image.
   always_comb
   begin
      one_shot_image                         = RDATA_RESET;
      one_shot_image[RLD_LSB +: ACT_W]       = st_ff.rld;
      one_shot_image[ACT_B_LSB +: ACT_W]     = st_ff.act_b;
      one_shot_image[ACT_A_LSB +: ACT_W]     = st_ff.act_a;
      continuous_image                       = RDATA_RESET;
      continuous_image[CSF_A_LSB +: CSF_W]   = rl.shadow;
   end

   // ************************************************************
   // Register update.
   // ************************************************************

   // Stores the one-shot register fields and captures read data.
   always_comb
   begin
      nxt_st       = st_ff;
      nxt_st.rdata = RDATA_RESET;
      if (wr_one_shot)
      begin
         nxt_st.rld   = reload_e'(reg_wdata[RLD_LSB +: ACT_W]);
         nxt_st.act_b = os_act[1];
         nxt_st.act_a = os_act[0];
      end
      if (rd_one_shot)
      begin
         nxt_st.rdata = one_shot_image;
      end
      else if (rd_continuous)
      begin
         nxt_st.rdata = continuous_image;
      end
   end

   // Registers the state.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff <= {RLD_RESET, ACT_RESET, ACT_RESET, RDATA_RESET};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;

   // ************************************************************
   // Continuous force reload.
   // ************************************************************

   // The reload point follows the stored mode, not the data of this write.
   assign rl.wr         = wr_continuous;
   assign rl.wdata      = reg_wdata[CSF_A_LSB +: CSF_W];
   assign rl.mode       = st_ff.rld;
   assign rl.zero_evt   = cnt_zero;
   assign rl.period_evt = cnt_period;

   csf_reload_unit u_reload
   (
      .clk  (clk),
      .rstn (rstn),
      .rl   (rl.unit)
   );

   // ************************************************************
   // Output channels.
   // ************************************************************

   // One channel per output; the direction of counting is never consulted.
   for (genvar g = 0; g < NUM_OUT; g++)
   begin : g_chan
      force_output_channel u_chan
      (
         .clk     (clk),
         .rstn    (rstn),
         .evt_act (evt_act[g]),
         .os_fire (os_fire[g]),
         .os_act  (os_act[g]),
         .csf     (csf_act[g]),
         .level   (level[g])
      );
   end

   assign pwm_output_a = level[0];
   assign pwm_output_b = level[1];

   // ************************************************************
   // Checks.
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_trig_read_zero: assert property (
      rd_one_shot |=> reg_rdata[TRIG_B_BIT] == 1'b0 && reg_rdata[TRIG_A_BIT] == 1'b0)
      else $error("Trigger bits read back as one.");

   a_trig_self_clear: assert property (
      wr_one_shot && reg_wdata[TRIG_A_BIT] ##1 rd_one_shot
      |=> reg_rdata[TRIG_A_BIT] == 1'b0)
      else $error("Trigger bit stayed set after its write.");

   a_unused_read_zero: assert property (
      rd_continuous |=> reg_rdata[REG_W-1:CSF_W] == '0)
      else $error("Unused continuous-force bits read as nonzero.");

   a_onesh_reserved: assert property (
      rd_one_shot |=> reg_rdata[REG_W-1:RLD_LSB+ACT_W] == '0)
      else $error("Unused one-shot bits read as nonzero.");

   a_reload_field_store: assert property (
      wr_one_shot ##1 rd_one_shot
      |=> reg_rdata[RLD_LSB +: ACT_W] == $past(reg_wdata[RLD_LSB +: ACT_W], 2))
      else $error("Reload select did not store the written value.");

   a_oneshot_b_set: assert property (
      os_fire[1] && os_act[1] == ACT_HIGH && csf_act[1] != ACT_LOW
      |=> pwm_output_b == 1'b1)
      else $error("One-shot set on output B not applied.");

   a_oneshot_a_clear: assert property (
      os_fire[0] && os_act[0] == ACT_LOW && csf_act[0] != ACT_HIGH
      |=> pwm_output_a == 1'b0)
      else $error("One-shot clear on output A not applied.");

   a_zero_write_noop: assert property (
      wr_one_shot && !reg_wdata[TRIG_A_BIT] && evt_act[0] == ACT_NONE
      && (csf_act[0] == ACT_NONE || csf_act[0] == ACT_TOGGLE)
      |=> $stable(pwm_output_a))
      else $error("Writing zero to a trigger changed output A.");

   a_imm_force_delay: assert property (
      wr_continuous && st_ff.rld == RLD_NOW && reg_wdata[CSF_A_LSB +: ACT_W] == ACT_HIGH
      |=> ##1 pwm_output_a == 1'b1)
      else $error("Immediate continuous force missed the following edge.");

   a_rdata_one_cycle: assert property (
      !reg_rd |=> reg_rdata == RDATA_RESET)
      else $error("Read data stood outside the answer cycle.");

   // ************************************************************
   // Output checks.
   // ************************************************************

   // An output is free when its active continuous code is 0h or 3h.
   logic free_a;
   logic free_b;

   always_comb
   begin
      free_a = 1'b1;
      free_b = 1'b1;
      if (csf_act[0] == ACT_LOW || csf_act[0] == ACT_HIGH)
      begin
         free_a = 1'b0;
      end
      if (csf_act[1] == ACT_LOW || csf_act[1] == ACT_HIGH)
      begin
         free_b = 1'b0;
      end
   end

   a_oneshot_b_toggle: assert property (
      os_fire[1] && os_act[1] == ACT_TOGGLE && free_b |=> pwm_output_b != $past(pwm_output_b))
      else $error("One-shot toggle on output B not applied.");

   a_oneshot_b_clear: assert property (
      os_fire[1] && os_act[1] == ACT_LOW && free_b |=> !pwm_output_b)
      else $error("One-shot clear on output B not applied.");

   a_oneshot_a_set: assert property (
      os_fire[0] && os_act[0] == ACT_HIGH && free_a |=> pwm_output_a)
      else $error("One-shot set on output A not applied.");

   a_oneshot_a_none: assert property (
      os_fire[0] && os_act[0] == ACT_NONE && free_a |=> $stable(pwm_output_a))
      else $error("One-shot with no action changed output A.");

   a_evt_b_override: assert property (
      !os_fire[1] && evt_act[1] == ACT_HIGH && free_b |=> pwm_output_b)
      else $error("Event action did not override output B.");

   a_csf_b_low: assert property (
      csf_act[1] == ACT_LOW |=> !pwm_output_b)
      else $error("Continuous low on output B not held.");

   a_csf_a_high: assert property (
      csf_act[0] == ACT_HIGH |=> pwm_output_a)
      else $error("Continuous high on output A not held.");

   a_csf_over_oneshot: assert property (
      os_fire[1] && csf_act[1] == ACT_LOW |=> !pwm_output_b)
      else $error("One-shot overrode a continuous force.");

   a_csf_over_event: assert property (
      evt_act[0] == ACT_LOW && csf_act[0] == ACT_HIGH |=> pwm_output_a)
      else $error("Event action overrode a continuous force.");

   a_shadow_no_early: assert property (
      wr_continuous && st_ff.rld != RLD_NOW && !cnt_zero && !cnt_period |=> $stable(rl.active))
      else $error("Shadow write reached the active copy early.");

   c_imm_force: cover property (wr_continuous && st_ff.rld == RLD_NOW);
   c_toggle_b: cover property (os_fire[1] && os_act[1] == ACT_TOGGLE);
   c_shadow_zero: cover property (wr_continuous && st_ff.rld == RLD_ZERO ##[1:20] cnt_zero);

endmodule

`default_nettype wire

/* logic/pwm_force_pkg.sv */
// Constants, field layouts and types shared by the PWM software force logic.
// How it works
// - Bits 7-6 pick continuous reload point.
// - Reload option 3h writes active register directly.
// - Writing 1 to bit 5 forces B once.
// - Writing 1 to bit 2 forces A once.
// - Zero writes ignored; trigger bits read zero.
// - Trigger bits clear themselves after the write.
// - Later action event overrides one-shot level.
// - Bits 4-3 select B one-shot action.
// - Bits 1-0 select A one-shot action.
// - One-shot ignores counter direction.
// - Immediate mode applies at next clock edge (here the active copy loads then; the output changes one edge later).
// - Shadow mode applies edge after transfer.
// - Bits 3-2 hold B low or high.
// - Bits 1-0 hold A low or high.
// - Unused upper bits read as zero.
`default_nettype none

package pwm_force_pkg;

   // ************************************************************
   // Register map and widths.
   // ************************************************************
   localparam int             REG_W           = 16;
   localparam int             ADDR_W          = 4;
   localparam int             ACT_W           = 2;
   localparam int             CSF_W           = 4;
   localparam int             NUM_OUT         = 2;
   localparam logic [3:0]     ADDR_ONE_SHOT   = 4'h0;
   localparam logic [3:0]     ADDR_CONTINUOUS = 4'h1;

   // ************************************************************
   // Field positions.
   // ************************************************************
   localparam int             RLD_LSB         = 6;
   localparam int             TRIG_B_BIT      = 5;
   localparam int             ACT_B_LSB       = 3;
   localparam int             TRIG_A_BIT      = 2;
   localparam int             ACT_A_LSB       = 0;
   localparam int             CSF_B_LSB       = 2;
   localparam int             CSF_A_LSB       = 0;

   // ************************************************************
   // Modes and actions.
   // ************************************************************
   typedef enum logic [1:0]
   {
      RLD_ZERO   = 2'b00,
      RLD_PERIOD = 2'b01,
      RLD_EITHER = 2'b10,
      RLD_NOW    = 2'b11
   } reload_e;

   // The same codes serve one-shot actions and continuous forces.
   typedef enum logic [1:0]
   {
      ACT_NONE   = 2'b00,
      ACT_LOW    = 2'b01,
      ACT_HIGH   = 2'b10,
      ACT_TOGGLE = 2'b11
   } action_e;

   // ************************************************************
   // Reset values.
   // ************************************************************
   localparam reload_e          RLD_RESET   = RLD_ZERO;
   localparam action_e          ACT_RESET   = ACT_NONE;
   localparam logic [CSF_W-1:0] CSF_RESET   = 4'h0;
   localparam logic [REG_W-1:0] RDATA_RESET = 16'h0000;
   localparam logic             LEVEL_RESET = 1'b0;

endpackage

`default_nettype wire

/* verification/pwm_action_software_force_tb_top.sv */
// Self-checking testbench for the PWM software force stage.
`default_nettype none

module pwm_action_software_force_tb_top
   import pwm_force_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // Signals and counters.
   // ************************************************************
   logic              clk;
   logic              rstn;
   logic [ADDR_W-1:0] reg_addr;
   logic [REG_W-1:0]  reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [REG_W-1:0]  reg_rdata;
   logic              cnt_zero;
   logic              cnt_period;
   logic [ACT_W-1:0]  evt_act_a;
   logic [ACT_W-1:0]  evt_act_b;
   logic              pwm_output_a;
   logic              pwm_output_b;
   int                error_cnt;
   int                checks;
   int                cycles;
   logic              ea;
   logic              eb;
   action_e           ta [5] = '{ACT_HIGH, ACT_NONE, ACT_LOW, ACT_TOGGLE, ACT_TOGGLE};
   action_e           tb [5] = '{ACT_TOGGLE, ACT_HIGH, ACT_NONE, ACT_LOW, ACT_TOGGLE};

   // ************************************************************
   // Device under test.
   // ************************************************************
   pwm_action_software_force u_pwm_action_software_force (
      .clk          (clk),
      .rstn         (rstn),
      .reg_addr     (reg_addr),
      .reg_wdata    (reg_wdata),
      .reg_wr       (reg_wr),
      .reg_rd       (reg_rd),
      .reg_rdata    (reg_rdata),
      .cnt_zero     (cnt_zero),
      .cnt_period   (cnt_period),
      .evt_act_a    (evt_act_a),
      .evt_act_b    (evt_act_b),
      .pwm_output_a (pwm_output_a),
      .pwm_output_b (pwm_output_b)
   );

   // The clock toggles every half period of 2.5 ns.
   always #2.5 clk = ~clk;

   // A hang is cut short after a fixed number of cycles.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         error_cnt++;
         $display("mismatch at %0t: run did not finish in time", $time);
         stop_test();
      end
   end

   // ************************************************************
   // Tasks.
   // ************************************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Compares one value and reports a difference at once.
   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask

   // Compares both output levels.
   task automatic lv(input logic a, input logic b);
      chk({14'h0000, pwm_output_a, pwm_output_b}, {14'h0000, a, b}, "output levels");
   endtask

   // One write cycle; returns just after the edge that takes it.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      #1;
   endtask

   // One read cycle; data stand only in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, e, "read data");
      @(posedge clk);
      #1;
      chk(reg_rdata, 16'h0000, "read data after its cycle");
   endtask

   // A write then a read of one index on back-to-back cycles.
   task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge clk);
      reg_rd    <= 1'b0;
      #1;
      chk(reg_rdata, e, "read after write");
   endtask

   // One-cycle counter event; checks levels just after the edge that loads the active copy and again one edge later.
   task automatic evt(input logic z, input logic p, input logic oa, input logic ob,
                      input logic na, input logic nb);
      @(posedge clk);
      cnt_zero   <= z;
      cnt_period <= p;
      @(posedge clk);
      cnt_zero   <= 1'b0;
      cnt_period <= 1'b0;
      #1;
      lv(oa, ob);
      @(posedge clk);
      #1;
      lv(na, nb);
   endtask

   // One cycle of event-table actions on both outputs.
   task automatic ev(input action_e a, input action_e b);
      @(posedge clk);
      evt_act_a <= a;
      evt_act_b <= b;
      @(posedge clk);
      evt_act_a <= ACT_NONE;
      evt_act_b <= ACT_NONE;
      #1;
   endtask

   // Expected level after a one-shot action.
   function automatic logic nl(input logic l, input action_e a);
      case (a)
         ACT_LOW:    return 1'b0;
         ACT_HIGH:   return 1'b1;
         ACT_TOGGLE: return ~l;
         default:    return l;
      endcase
   endfunction

   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial
   begin
      clk = 1'b0; rstn = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0;
      reg_rd = 1'b0; cnt_zero = 1'b0; cnt_period = 1'b0; evt_act_a = '0; evt_act_b = '0;
      error_cnt = 0; checks = 0; cycles = 0; ea = 1'b0; eb = 1'b0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      #1;
      lv(1'b0, 1'b0);
      rd(ADDR_ONE_SHOT, 16'h0000);
      rd(ADDR_CONTINUOUS, 16'h0000);
      // Every one-shot action on both outputs, fired together.
      for (int i = 0; i < 5; i++)
      begin
         wr(ADDR_ONE_SHOT, {8'h00, 2'b00, 1'b1, tb[i], 1'b1, ta[i]});
         ea = nl(ea, ta[i]);
         eb = nl(eb, tb[i]);
         lv(ea, eb);
      end
      rd(ADDR_ONE_SHOT, 16'h001B);
      wr(ADDR_ONE_SHOT, 16'h0012);
      lv(1'b0, 1'b1);
      rd(ADDR_ONE_SHOT, 16'h0012);
      wr_rd(ADDR_ONE_SHOT, 16'h0044, 16'h0040);
      // A toggle must act once only.
      wr(ADDR_ONE_SHOT, 16'h003F);
      lv(1'b1, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      lv(1'b1, 1'b0);
      ev(ACT_LOW, ACT_HIGH);
      lv(1'b0, 1'b1);
      // Shadow reload on zero: period event must not load.
      wr(ADDR_ONE_SHOT, 16'h0000);
      wr(ADDR_CONTINUOUS, 16'h0006);
      repeat (2) @(posedge clk);
      #1;
      lv(1'b0, 1'b1);
      rd(ADDR_CONTINUOUS, 16'h0006);
      evt(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      evt(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      // Continuous force wins over one-shot and event actions.
      wr(ADDR_ONE_SHOT, 16'h0035);
      lv(1'b1, 1'b0);
      ev(ACT_LOW, ACT_HIGH);
      lv(1'b1, 1'b0);
      // Shadow reload on period.
      wr(ADDR_ONE_SHOT, 16'h0040);
      wr(ADDR_CONTINUOUS, 16'h0009);
      evt(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      evt(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
      // Shadow reload on either event.
      wr(ADDR_ONE_SHOT, 16'h0080);
      wr(ADDR_CONTINUOUS, 16'h0006);
      evt(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      wr(ADDR_CONTINUOUS, 16'h0009);
      evt(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      // Code 3h releases the force; one-shots act again.
      wr(ADDR_CONTINUOUS, 16'h000F);
      evt(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      wr(ADDR_ONE_SHOT, 16'h00BF);
      lv(1'b1, 1'b0);
      // Immediate mode: force lands one edge after the write.
      wr(ADDR_ONE_SHOT, 16'h00C0);
      wr(ADDR_CONTINUOUS, 16'h0009);
      lv(1'b1, 1'b0);
      @(posedge clk);
      #1;
      lv(1'b0, 1'b1);
      rd(ADDR_CONTINUOUS, 16'h0009);
      wr(ADDR_CONTINUOUS, 16'h0006);
      lv(1'b0, 1'b1);
      @(posedge clk);
      #1;
      lv(1'b1, 1'b0);
      // Unused bits read as zero.
      wr(ADDR_CONTINUOUS, 16'hFFF0);
      rd(ADDR_CONTINUOUS, 16'h0000);
      wr(ADDR_ONE_SHOT, 16'hFFFF);
      lv(1'b0, 1'b1);
      rd(ADDR_ONE_SHOT, 16'h00DB);
      // Unmapped index: writes ignored, reads zero.
      wr(4'h9, 16'h0025);
      @(posedge clk);
      #1;
      lv(1'b0, 1'b1);
      rd(4'h9, 16'h0000);
      // Second reset in mid-run.
      @(posedge clk);
      rstn <= 1'b0;
      @(posedge clk);
      rstn <= 1'b1;
      #1;
      lv(1'b0, 1'b0);
      rd(ADDR_ONE_SHOT, 16'h0000);
      rd(ADDR_CONTINUOUS, 16'h0000);
      stop_test();
   end

endmodule

`default_nettype wire
